// ### sim/dfo_bench.sv
`timescale 1ns/1ns
module dfo_bench;
   import dfo_pkg::*;
   logic        clock, rst, follow_err;
   logic [31:0] slow_d, quick_d, cyc;
   dfo_req_t    req;
   dfo_rsp_t    rsp, r;
   dfo_meas_t   meas;
   dfo_stop_t   stop;
   int          errors, check_count;
   dfo_top dut_u (.clock(clock), .rst(rst), .req(req), .rsp(rsp), .meas(meas), .follow_err(follow_err),
      .mode_slow_decel(slow_d), .mode_quick_decel(quick_d), .stop(stop), .cyclic_supply_mv(cyc));
   dfo_master master_u (.clock(clock), .req(req), .rsp(rsp));
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   // ****************************************
   // compares, accesses, verdict
   // ****************************************
   task cmp32(string n, logic [31:0] e, logic [31:0] s);
      check_count++;
      if (s !== e) begin
         errors++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask
   task cmpab(string n, dfo_abort_t e, dfo_abort_t s);
      check_count++;
      if (s !== e) begin
         errors++;
         $display("mismatch %s expected %0d seen %0d", n, e, s);
      end
   endtask
   task rd(logic [15:0] i, logic [7:0] s, logic [31:0] e, dfo_abort_t ea);
      master_u.xfer(1'b0, i, s, 32'h0, r);
      cmpab("read abort", ea, r.abort);
      cmp32("read data", e, r.rdata);
   endtask
   task wr(logic [15:0] i, logic [7:0] s, logic [31:0] d, dfo_abort_t ea);
      master_u.xfer(1'b1, i, s, d, r);
      cmpab("write abort", ea, r.abort);
   endtask
   task conclude();
      $display("checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // about 36 transfers of two cycles each; the limit leaves ample margin
   initial begin
      #20000;
      errors++;
      conclude();
   end
   initial begin
      rst = 1'b1;
      follow_err = 1'b0;
      slow_d = 32'h0000_1234;
      quick_d = 32'h0000_5678;
      meas = '{1'b0, 32'h0000_8000, 32'h0000_5dc0, 32'hffff_ec78, 32'hffff_ff9c};
      repeat (20) @(negedge clock);
      rst = 1'b0;
      rd(16'h3700, 8'h00, 32'hffff_ffff, DFO_ABORT_NONE);
      for (int c = -1; c <= 2; c++) begin
         wr(16'h3700, 8'h00, 32'(c), DFO_ABORT_NONE);
         rd(16'h3700, 8'h00, 32'(c), DFO_ABORT_NONE);
         follow_err = 1'b1;
         @(negedge clock);
         cmp32("stop", (c < 0) ? 32'h0 : 32'h4 >> c, {stop.halt_now, stop.brake_slow, stop.brake_quick});
         cmp32("brake decel", (c == 1) ? slow_d : (c == 2) ? quick_d : 32'h0, stop.brake_decel);
         follow_err = 1'b0;
         @(negedge clock);
         cmp32("stop released", 32'h0, {stop.halt_now, stop.brake_slow, stop.brake_quick});
         $display("test reaction code %0d done", c);
      end
      wr(16'h3700, 8'h00, 32'h0000_0003, DFO_ABORT_BAD_VALUE);
      wr(16'h3700, 8'h00, 32'h0000_fffe, DFO_ABORT_BAD_VALUE);
      rd(16'h3700, 8'h00, 32'h0000_0002, DFO_ABORT_NONE);
      rd(16'h4012, 8'h01, 32'h0, DFO_ABORT_NONE);
      meas.nvm_fitted = 1'b1;
      rd(16'h4012, 8'h01, 32'h0000_8000, DFO_ABORT_NONE);
      $display("test codes and memory size done");
      rd(16'h4014, 8'h01, 32'h0000_5dc0, DFO_ABORT_NONE);
      rd(16'h4014, 8'h02, 32'hffff_ec78, DFO_ABORT_NONE);
      rd(16'h4014, 8'h03, 32'hffff_ff9c, DFO_ABORT_NONE);
      cmp32("cyclic supply", 32'h0000_5dc0, cyc);
      wr(16'h4014, 8'h01, 32'h0, DFO_ABORT_READ_ONLY);
      wr(16'h4014, 8'h02, 32'h0, DFO_ABORT_READ_ONLY);
      rd(16'h4014, 8'h01, 32'h0000_5dc0, DFO_ABORT_NONE);
      $display("test conditions done");
      // reserved bit 0 of the configuration word must read back as zero
      wr(16'h4013, 8'h01, 32'hffff_ffff, DFO_ABORT_NONE);
      rd(16'h4013, 8'h01, 32'hffff_fffe, DFO_ABORT_NONE);
      rd(16'h4013, 8'h00, 32'h0000_0001, DFO_ABORT_NONE);
      wr(16'h4013, 8'h00, 32'h0, DFO_ABORT_READ_ONLY);
      rd(16'h4012, 8'h00, 32'h0000_0001, DFO_ABORT_NONE);
      rd(16'h4014, 8'h00, 32'h0000_0003, DFO_ABORT_NONE);
      wr(16'h3700, 8'h01, 32'h0, DFO_ABORT_NO_SUBINDEX);
      rst = 1'b1;
      repeat (2) @(negedge clock);
      rst = 1'b0;
      rd(16'h3700, 8'h00, 32'hffff_ffff, DFO_ABORT_NONE);
      rd(16'h4013, 8'h01, 32'h0, DFO_ABORT_NONE);
      $display("test configuration and reset done");
      rd(16'h4040, 8'h00, 32'h3030_4e53, DFO_ABORT_NONE);
      rd(16'h4040, 8'h01, 32'h3130_3030, DFO_ABORT_NONE);
      rd(16'h4040, 8'h02, 32'h0, DFO_ABORT_NO_SUBINDEX);
      wr(16'h4040, 8'h00, 32'h0, DFO_ABORT_READ_ONLY);
      rd(16'h4041, 8'h00, 32'h0403_0201, DFO_ABORT_NONE);
      wr(16'h4041, 8'h00, 32'h0, DFO_ABORT_READ_ONLY);
      rd(16'h4015, 8'h00, 32'h0, DFO_ABORT_NO_OBJECT);
      $display("test strings done");
      conclude();
   end
endmodule // dfo_bench
bind dfo_top dfo_properties chk_u (.clock(clock), .rst(rst), .req(req), .rsp(rsp), .meas(meas),
   .follow_err(follow_err), .mode_slow_decel(mode_slow_decel), .mode_quick_decel(mode_quick_decel),
   .stop(stop), .cyclic_supply_mv(cyclic_supply_mv));

// ### sim/dfo_master.sv
`timescale 1ns/1ns
module dfo_master (
   input  wire logic              clock,
   output      dfo_pkg::dfo_req_t req,
   input  wire dfo_pkg::dfo_rsp_t rsp
);
   import dfo_pkg::*;
   initial req = '0;
   // ****************************************
   // one transfer: strobe for one cycle, answer taken with the ack
   // ****************************************
   // released fields are inverted so a stale value is never read as valid
   task automatic xfer(input logic w, input logic [15:0] i, input logic [7:0] s, input logic [31:0] d,
                       output dfo_rsp_t r);
      @(negedge clock);
      req <= '{valid: 1'b1, write: w, index: i, subindex: s, wdata: d};
      @(negedge clock);
      r = rsp;
      req <= '{valid: 1'b0, write: ~w, index: ~i, subindex: ~s, wdata: ~d};
   endtask
endmodule // dfo_master

// ### sim/dfo_properties.sv
`timescale 1ns/1ns
module dfo_properties (
   input wire logic               clock,
   input wire logic               rst,
   input wire dfo_pkg::dfo_req_t  req,
   input wire dfo_pkg::dfo_rsp_t  rsp,
   input wire dfo_pkg::dfo_meas_t meas,
   input wire logic               follow_err,
   input wire logic [31:0]        mode_slow_decel,
   input wire logic [31:0]        mode_quick_decel,
   input wire dfo_pkg::dfo_stop_t stop,
   input wire logic [31:0]        cyclic_supply_mv
);
   import dfo_pkg::*;
   // ****************************************
   // shadow of the stored reaction code
   // ****************************************
   // the shadow lags the design by one edge, so reactions are judged only away from writes
   logic        pend_reg;
   logic [15:0] wd_reg;
   logic [15:0] code_reg;
   always_ff @(posedge clock) begin
      pend_reg <= !rst && req.valid && req.write && req.index == 16'h3700;
      wd_reg   <= req.wdata[15:0];
      if (rst)
         code_reg <= 16'hffff;
      else if (pend_reg && rsp.abort == DFO_ABORT_NONE)
         code_reg <= wd_reg;
   end
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   sequence s_react(logic [15:0] c);
      follow_err && !pend_reg && code_reg == c;
   endsequence
   sequence s_fe_wr;
      req.valid && req.write && req.index == 16'h3700 && req.subindex == 8'h00;
   endsequence
   property p_none; s_react(16'hffff) |=> stop == '0; endproperty
   property p_halt; s_react(16'h0000) |=> stop.halt_now && !stop.brake_slow && !stop.brake_quick; endproperty
   property p_slow; s_react(16'h0001) |=> stop.brake_slow && stop.brake_decel == $past(mode_slow_decel); endproperty
   property p_quick; s_react(16'h0002) |=> stop.brake_quick && stop.brake_decel == $past(mode_quick_decel); endproperty
   property p_drop; !follow_err |=> !stop.halt_now && !stop.brake_slow && !stop.brake_quick; endproperty
   property p_bad; s_fe_wr ##0 (req.wdata[15:0] inside {[16'h0003:16'hfffe]}) |=> rsp.abort == DFO_ABORT_BAD_VALUE;
   endproperty
   property p_ro; req.valid && req.write && req.index == 16'h4014 && req.subindex < 8'h04
      |=> rsp.ack && rsp.abort == DFO_ABORT_READ_ONLY; endproperty
   property p_cyc; !$past(rst) |-> cyclic_supply_mv == $past(meas.supply_rail_power_mv); endproperty
   property p_ack; req.valid |=> rsp.ack ##1 (rsp.ack == $past(req.valid)); endproperty
   a_none: assert property (p_none) else $error("reaction output with code -1");
   a_halt: assert property (p_halt) else $error("no halt with code 0");
   a_slow: assert property (p_slow) else $error("slow ramp wrong");
   a_quick: assert property (p_quick) else $error("quick ramp wrong");
   a_drop: assert property (p_drop) else $error("reaction without error");
   a_bad: assert property (p_bad) else $error("reserved code accepted");
   a_ro: assert property (p_ro) else $error("conditions write accepted");
   a_cyc: assert property (p_cyc) else $error("cyclic supply copy wrong");
   a_ack: assert property (p_ack) else $error("ack not one cycle after request");
endmodule // dfo_properties

// ### src/dfo_defines.svh
// Operation
// - following error: code -1 does nothing, code 0 halts motion at once
// - code 1 brakes on the slow-down ramp with the active mode's deceleration
// - code 2 brakes on the quick-stop ramp with the active mode's deceleration
// - report non-volatile memory size in bytes, zero when none is fitted
// - main supply voltage read-only, signed 32-bit millivolts, also cyclic output
// - logic supply voltage read-only, signed 32-bit millivolts
// - board temperature read-only, signed 32-bit, degrees times 10
// - serial number is a read-only text string, writes refused
// - unit identifier is a read-only byte string, writes refused
`ifndef DFO_DEFINES_SVH
`define DFO_DEFINES_SVH

// ****************************************
// object indexes
// ****************************************
`define DFO_IDX_FE_REACTION  16'h3700
`define DFO_IDX_HW_INFO      16'h4012
`define DFO_IDX_HW_CONFIG    16'h4013
`define DFO_IDX_OP_COND      16'h4014
`define DFO_IDX_SERIAL       16'h4040
`define DFO_IDX_UNIT_ID      16'h4041

// ****************************************
// subindexes and counts
// ****************************************
`define DFO_SUB_COUNT        8'h00
`define DFO_SUB_FIRST        8'h01
`define DFO_SUB_LOGIC        8'h02
`define DFO_SUB_TEMP         8'h03
`define DFO_HW_INFO_TOP      8'h01
`define DFO_HW_CONFIG_TOP    8'h01
`define DFO_OP_COND_TOP      8'h03

// ****************************************
// reset values and fields
// ****************************************
`define DFO_FE_REACTION_RST  16'hffff
`define DFO_FE_CODE_MIN      16'hffff
`define DFO_FE_CODE_MAX      16'h0002
`define DFO_HW_CONFIG_RST    32'h0000_0000
`define DFO_HW_CONFIG_RSVD   32'h0000_0001
`define DFO_STRING_RST       32'h0000_0000

`endif

// ### src/dfo_pkg.sv
package dfo_pkg;

   typedef enum logic [1:0] {
      DFO_REACT_NONE,
      DFO_REACT_HALT,
      DFO_REACT_SLOW,
      DFO_REACT_QUICK
   } dfo_react_t;

   typedef enum logic [2:0] {
      DFO_ABORT_NONE,
      DFO_ABORT_NO_OBJECT,
      DFO_ABORT_NO_SUBINDEX,
      DFO_ABORT_READ_ONLY,
      DFO_ABORT_BAD_VALUE
   } dfo_abort_t;

   typedef struct packed {
      logic        valid;
      logic        write;
      logic [15:0] index;
      logic [7:0]  subindex;
      logic [31:0] wdata;
   } dfo_req_t;

   typedef struct packed {
      logic        ack;
      dfo_abort_t  abort;
      logic [31:0] rdata;
   } dfo_rsp_t;

   typedef struct packed {
      logic        nvm_fitted;
      logic [31:0] nvm_size_bytes;
      logic [31:0] supply_rail_power_mv;
      logic [31:0] supply_rail_logic_mv;
      logic [31:0] board_temp_dc;
   } dfo_meas_t;

   typedef struct packed {
      logic        halt_now;
      logic        brake_slow;
      logic        brake_quick;
      logic [31:0] brake_decel;
   } dfo_stop_t;

endpackage

// ### src/dfo_string_rom.sv
`timescale 1ns/1ns
module dfo_string_rom #(
   parameter int                 LEN  = 8,
   parameter logic [8*LEN-1:0]   TEXT = '0
) (
   input  wire logic [7:0]  segment,
   output logic [31:0] word,
   output logic        in_range
);
   import dfo_pkg::*;

   // ****************************************
   // four characters per segment, first character in the low byte
   // ****************************************
   logic [7:0] chars [0:LEN-1];
   int         base;

   always_comb begin
      for (int i = 0; i < LEN; i++) begin
         chars[i] = TEXT[8*(LEN-1-i) +: 8];
      end
   end

   always_comb begin
      base     = 4 * int'(segment);
      word     = 32'h0000_0000;
      in_range = (base < LEN);
      for (int b = 0; b < 4; b++) begin
         if (base + b < LEN) begin
            word[8*b +: 8] = chars[base + b];
         end
      end
   end

endmodule // dfo_string_rom

// ### src/dfo_top.sv
`timescale 1ns/1ns
`include "dfo_defines.svh"
module dfo_top #(
   parameter int                  SERIAL_LEN  = 8,
   // arbitrary value
   parameter logic [8*SERIAL_LEN-1:0] SERIAL_TEXT = "SN000001",
   parameter int                  UNIT_ID_LEN = 4,
   // arbitrary value
   parameter logic [8*UNIT_ID_LEN-1:0] UNIT_ID_BYTES = 32'h0102_0304
) (
   input  wire logic              clock,
   input  wire logic              rst,
   input  wire dfo_pkg::dfo_req_t  req,
   output      dfo_pkg::dfo_rsp_t  rsp,
   input  wire dfo_pkg::dfo_meas_t meas,
   input  wire logic              follow_err,
   input  wire logic [31:0]       mode_slow_decel,
   input  wire logic [31:0]       mode_quick_decel,
   output      dfo_pkg::dfo_stop_t stop,
   output      logic [31:0]       cyclic_supply_mv
);
   import dfo_pkg::*;

   // ****************************************
   // state
   // ****************************************
   logic [15:0] fe_reaction_reg;
   logic [31:0] hw_config_reg;
   dfo_meas_t   meas_reg;
   dfo_rsp_t    rsp_reg;
   dfo_rsp_t    rsp_next;
   dfo_stop_t   stop_reg;
   dfo_react_t  react;
   logic [31:0] cyclic_reg;
   logic [31:0] serial_word;
   logic        serial_ok;
   logic [31:0] unit_word;
   logic        unit_ok;
   logic        fe_write_ok;
   logic        cfg_write_ok;

   // ****************************************
   // signed window check on a 16-bit option code
   // ****************************************
   function automatic logic code_allowed(input logic [15:0] code);
      return ($signed(code) >= $signed(`DFO_FE_CODE_MIN)) && ($signed(code) <= $signed(`DFO_FE_CODE_MAX));
   endfunction

   function automatic dfo_react_t decode_code(input logic [15:0] code);
      dfo_react_t r;
      r = DFO_REACT_NONE;
      case (code)
         16'h0000: r = DFO_REACT_HALT;
         16'h0001: r = DFO_REACT_SLOW;
         16'h0002: r = DFO_REACT_QUICK;
         default:  r = DFO_REACT_NONE;
      endcase
      return r;
   endfunction

   // ****************************************
   // string objects
   // ****************************************
   dfo_string_rom #(
      .LEN  (SERIAL_LEN),
      .TEXT (SERIAL_TEXT)
   ) u_serial (
      .segment  (req.subindex),
      .word     (serial_word),
      .in_range (serial_ok)
   );

   dfo_string_rom #(
      .LEN  (UNIT_ID_LEN),
      .TEXT (UNIT_ID_BYTES)
   ) u_unit_id (
      .segment  (req.subindex),
      .word     (unit_word),
      .in_range (unit_ok)
   );

   // ****************************************
   // live readings, sampled each cycle so a read sees one consistent snapshot edge
   // ****************************************
   always_ff @(posedge clock) begin
      if (rst) begin
         meas_reg   <= '0;
         cyclic_reg <= 32'h0000_0000;
      end else begin
         meas_reg   <= meas;
         cyclic_reg <= meas.supply_rail_power_mv;
      end
   end

   // ****************************************
   // object access decode
   // ****************************************
   always_comb begin
      rsp_next       = '0;
      rsp_next.ack   = req.valid;
      rsp_next.abort = DFO_ABORT_NONE;
      fe_write_ok    = 1'b0;
      cfg_write_ok   = 1'b0;
      if (!req.valid) begin
         rsp_next.ack = 1'b0;
      end else if (req.index == `DFO_IDX_FE_REACTION) begin
         if (req.subindex != `DFO_SUB_COUNT) begin
            rsp_next.abort = DFO_ABORT_NO_SUBINDEX;
         end else if (req.write) begin
            if (code_allowed(req.wdata[15:0])) begin
               fe_write_ok = 1'b1;
            end else begin
               rsp_next.abort = DFO_ABORT_BAD_VALUE;
            end
         end else begin
            rsp_next.rdata = {{16{fe_reaction_reg[15]}}, fe_reaction_reg};
         end
      end else if (req.index == `DFO_IDX_HW_INFO) begin
         if (req.write) begin
            rsp_next.abort = DFO_ABORT_READ_ONLY;
         end else if (req.subindex == `DFO_SUB_COUNT) begin
            rsp_next.rdata = {24'h00_0000, `DFO_HW_INFO_TOP};
         end else if (req.subindex == `DFO_SUB_FIRST) begin
            rsp_next.rdata = meas_reg.nvm_fitted ? meas_reg.nvm_size_bytes : 32'h0000_0000;
         end else begin
            rsp_next.abort = DFO_ABORT_NO_SUBINDEX;
         end
      end else if (req.index == `DFO_IDX_HW_CONFIG) begin
         if (req.subindex == `DFO_SUB_COUNT) begin
            if (req.write) begin
               rsp_next.abort = DFO_ABORT_READ_ONLY;
            end else begin
               rsp_next.rdata = {24'h00_0000, `DFO_HW_CONFIG_TOP};
            end
         end else if (req.subindex == `DFO_SUB_FIRST) begin
            if (req.write) begin
               cfg_write_ok = 1'b1;
            end else begin
               rsp_next.rdata = hw_config_reg;
            end
         end else begin
            rsp_next.abort = DFO_ABORT_NO_SUBINDEX;
         end
      end else if (req.index == `DFO_IDX_OP_COND) begin
         if (req.write) begin
            rsp_next.abort = DFO_ABORT_READ_ONLY;
         end else if (req.subindex == `DFO_SUB_COUNT) begin
            rsp_next.rdata = {24'h00_0000, `DFO_OP_COND_TOP};
         end else if (req.subindex == `DFO_SUB_FIRST) begin
            rsp_next.rdata = meas_reg.supply_rail_power_mv;
         end else if (req.subindex == `DFO_SUB_LOGIC) begin
            rsp_next.rdata = meas_reg.supply_rail_logic_mv;
         end else if (req.subindex == `DFO_SUB_TEMP) begin
            rsp_next.rdata = meas_reg.board_temp_dc;
         end else begin
            rsp_next.abort = DFO_ABORT_NO_SUBINDEX;
         end
      end else if (req.index == `DFO_IDX_SERIAL) begin
         if (req.write) begin
            rsp_next.abort = DFO_ABORT_READ_ONLY;
         end else if (serial_ok) begin
            rsp_next.rdata = serial_word;
         end else begin
            rsp_next.abort = DFO_ABORT_NO_SUBINDEX;
         end
      end else if (req.index == `DFO_IDX_UNIT_ID) begin
         if (req.write) begin
            rsp_next.abort = DFO_ABORT_READ_ONLY;
         end else if (unit_ok) begin
            rsp_next.rdata = unit_word;
         end else begin
            rsp_next.abort = DFO_ABORT_NO_SUBINDEX;
         end
      end else begin
         rsp_next.abort = DFO_ABORT_NO_OBJECT;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         rsp_reg <= '0;
      end else begin
         rsp_reg <= rsp_next;
      end
   end

   // ****************************************
   // writable objects
   // ****************************************
   always_ff @(posedge clock) begin
      if (rst) begin
         fe_reaction_reg <= `DFO_FE_REACTION_RST;
      end else if (fe_write_ok) begin
         fe_reaction_reg <= req.wdata[15:0];
      end
   end

   // reserved bit 0 stays zero whatever is written
   always_ff @(posedge clock) begin
      if (rst) begin
         hw_config_reg <= `DFO_HW_CONFIG_RST;
      end else if (cfg_write_ok) begin
         hw_config_reg <= req.wdata & ~`DFO_HW_CONFIG_RSVD;
      end
   end

   // ****************************************
   // following error reaction
   // ****************************************
   // reaction follows the code stored when the error is present; a code change mid-error retargets next cycle
   assign react = decode_code(fe_reaction_reg);

   always_ff @(posedge clock) begin
      if (rst) begin
         stop_reg <= '0;
      end else if (!follow_err) begin
         stop_reg <= '0;
      end else begin
         stop_reg.halt_now    <= (react == DFO_REACT_HALT);
         stop_reg.brake_slow  <= (react == DFO_REACT_SLOW);
         stop_reg.brake_quick <= (react == DFO_REACT_QUICK);
         case (react)
            DFO_REACT_SLOW:  stop_reg.brake_decel <= mode_slow_decel;
            DFO_REACT_QUICK: stop_reg.brake_decel <= mode_quick_decel;
            default:         stop_reg.brake_decel <= 32'h0000_0000;
         endcase
      end
   end

   assign rsp              = rsp_reg;
   assign stop             = stop_reg;
   assign cyclic_supply_mv = cyclic_reg;

endmodule // dfo_top
